/* rtl/octal_enable_pkg.sv */
// Constants shared by the descriptor table and its host reader: the field
// layout of the two octal single-rate enable descriptor words, the host's
// register map and the reset values of its state.
// Assumes both ends are compiled against this one package.
package octal_enable_pkg;

    // ------------------------------------------------------------------
    // Descriptor word selection and field positions
    // ------------------------------------------------------------------
    localparam logic       WORD_VOLATILE   = 1'b0;
    localparam logic       WORD_PERSISTENT = 1'b1;
    localparam int         POS_AVAILABLE   = 31;
    localparam int         POS_POLARITY    = 30;
    localparam int         POS_RSVD_OTP    = 29;
    localparam int         POS_ADDRESSED   = 28;
    localparam int         POS_BYTE1       = 27;
    localparam int         POS_BITLOC_LO   = 24;
    localparam int         POS_LOCAL_LO    = 16;
    localparam int         POS_MODE_8D     = 23;
    localparam int         POS_MODE_8S     = 22;
    localparam int         POS_MODE_4S4D   = 21;
    localparam int         POS_MODE_4S     = 20;
    localparam int         POS_DUMMY_LO    = 16;
    localparam int         POS_RD_OP_LO    = 8;
    localparam int         POS_WR_OP_LO    = 0;
    localparam logic [7:0] OPCODE_NONE     = 8'h00;
    localparam logic [3:0] DUMMY_SINGLE    = 4'h0;

    // ------------------------------------------------------------------
    // Host register map, one aligned word each
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL     = 8'h00;
    localparam logic [7:0] OFS_STATUS      = 8'h04;
    localparam logic [7:0] OFS_VOL_RAW     = 8'h08;
    localparam logic [7:0] OFS_PER_RAW     = 8'h0C;
    localparam logic [7:0] OFS_VOL_PLAN    = 8'h10;
    localparam logic [7:0] OFS_PER_PLAN    = 8'h14;
    localparam int         CTL_FETCH       = 0;
    localparam int         CTL_WIDTH_LO    = 1;
    localparam logic [1:0] WIDTH_8         = 2'h0;
    localparam logic [1:0] WIDTH_24        = 2'h1;
    localparam logic [1:0] WIDTH_32        = 2'h2;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;
    localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
    localparam logic [1:0] RESET_WIDTH     = WIDTH_24;

    typedef enum logic [1:0] {
        FETCH_IDLE,
        FETCH_ASK
    } fetch_state_type;

endpackage

/* rtl/desc_link_if.sv */
// Link between the descriptor table and the host that reads it.
// Assumes a single clock shared by both ends; the bench ties the modports.
`timescale 1ns/1ps
interface desc_link_if;
    logic        req;    // Held high until the persistent word's ack
    logic        index;  // Word asked for: volatile or persistent
    logic        ack;    // One-cycle answer strobe
    logic [31:0] data;   // Word, valid while ack is high

    modport table_end (input req, input index, output ack, output data);
    modport host_end  (output req, output index, input ack, input data);
endinterface

/* rtl/octal_enable_table.sv */
// Descriptor table end: answers word requests with the two octal
// single-rate enable descriptor words built from its parameters.
// Assumes the host holds req and index steady until ack.
`timescale 1ns/1ps
module octal_enable_table
    import octal_enable_pkg::*;
#(
    parameter logic       VOL_AVAILABLE = 1'b1,
    parameter logic       VOL_INVERTED  = 1'b0,
    parameter logic       VOL_ADDRESSED = 1'b0,
    parameter logic       VOL_BYTE1     = 1'b0,
    parameter logic [2:0] VOL_BITLOC    = 3'h0,
    parameter logic [7:0] VOL_MIDDLE    = 8'hC8,
    parameter logic [7:0] VOL_RD_OP     = 8'h05,
    parameter logic [7:0] VOL_WR_OP     = 8'h01,
    parameter logic       PER_AVAILABLE = 1'b1,
    parameter logic       PER_INVERTED  = 1'b0,
    parameter logic       PER_OTP       = 1'b0,
    parameter logic       PER_ADDRESSED = 1'b1,
    parameter logic       PER_BYTE1     = 1'b0,
    parameter logic [2:0] PER_BITLOC    = 3'h3,
    parameter logic [7:0] PER_MIDDLE    = 8'h00,
    parameter logic [7:0] PER_RD_OP     = 8'h71,
    parameter logic [7:0] PER_WR_OP     = 8'h72
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    desc_link_if.table_end           link,
    output      logic [3:0]          single_lane_dummy
);
    import octal_enable_pkg::*;

    // ------------------------------------------------------------------
    // Word images
    // ------------------------------------------------------------------
    // Reserved bit of the volatile word is tied low so future use is safe
    localparam logic [31:0] VOL_WORD = {VOL_AVAILABLE,  // [R1]
        VOL_INVERTED,                                   // [R2]
        1'b0,                                           // [R3]
        VOL_ADDRESSED, VOL_BYTE1, VOL_BITLOC,           // [R4] [R5] [R7]
        VOL_MIDDLE,                                     // [R8] [R9] [R13]
        VOL_RD_OP, VOL_WR_OP};                          // [R16] [R17]
    localparam logic [31:0] PER_WORD = {PER_AVAILABLE,  // [R18]
        PER_INVERTED, PER_OTP,                          // [R19] [R20]
        PER_ADDRESSED, PER_BYTE1, PER_BITLOC,
        PER_MIDDLE, PER_RD_OP, PER_WR_OP};

    logic        ack_q, ack_d;
    logic [31:0] data_q, data_d;
    logic [3:0]  dummy_q, dummy_d;

    // ------------------------------------------------------------------
    // Answer logic
    // ------------------------------------------------------------------
    // ack_q blocks an answer only in the cycle after each ack; a held req is answered every other cycle
    always_comb begin
        ack_d   = link.req & ~ack_q;
        data_d  = data_q;
        dummy_d = DUMMY_SINGLE;                          // [R14]
        if (link.req && !ack_q) begin
            data_d = (link.index == WORD_PERSISTENT) ? PER_WORD : VOL_WORD;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_q   <= 1'b0;
            data_q  <= RESET_WORD;
            dummy_q <= DUMMY_SINGLE;
        end else begin
            ack_q   <= ack_d;
            data_q  <= data_d;
            dummy_q <= dummy_d;
        end
    end

    assign link.ack          = ack_q;
    assign link.data         = data_q;
    assign single_lane_dummy = dummy_q;
endmodule

/* rtl/octal_enable_host.sv */
// Host end: fetches both octal single-rate enable descriptor words on
// software command and turns them into a ready-to-use access plan.
// Assumes an AXI4-Lite master on the register side, the table on the link.
//
// What this block does
// R1: Volatile word bit 31 flags enable present
// R2: Volatile bit 30 selects enable polarity
// R3: Volatile bit 29 reserved, reads zero
// R4: Bit 28 selects direct or addressed access
// R5: Bit 27 places local address byte
// R6: Never place address in byte 1 with 8-bit
// R7: Bits 26-24 give enable bit position
// R8: Addressed access: bits 23-16 local address
// R9: Direct access: bit 23 flags 8D mode
// R10: Direct access: bit 22 flags 8S mode
// R11: Direct access: bit 21 flags 4S-4D-4D mode
// R12: Direct access: bit 20 flags 4S mode
// R13: Direct access: bits 19-16 give dummy cycle count
// R14: Single-lane command needs no dummy cycles
// R15: Unflagged modes are not assumed unusable
// R16: Bits 15-8 read opcode, zero means none
// R17: Bits 7-0 write opcode, zero means none
// R18: Persistent word bit 31 flags enable present
// R19: Persistent bit 30 selects enable polarity
// R20: Persistent bit 29 flags one-time programmable
// R21: Check presence, polarity, opcode before writing
`timescale 1ns/1ps
module octal_enable_host
    import octal_enable_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    desc_link_if.host_end    link,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output      logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output      logic        wready,
    output      logic [1:0]  bresp,
    output      logic        bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output      logic        arready,
    output      logic [31:0] rdata,
    output      logic [1:0]  rresp,
    output      logic        rvalid,
    input  wire logic        rready
);
    import octal_enable_pkg::*;

    // ------------------------------------------------------------------
    // Plan decoding
    // ------------------------------------------------------------------
    // Plan layout: [7:0] mask, [11:8] dummy, [12] enable value,
    // [13] write ok, [14] read ok, [15] addressed, [16] byte1,
    // [17] placement illegal, [18] one-time, [22:19] modes, [31:24] addr.
    // Mode flags only say which modes use the listed dummy count; a
    // clear flag is reported as is and nothing is disabled by it.
    function automatic logic [31:0] decode_plan(input logic [31:0] w,
                                                input logic        pers,
                                                input logic [1:0]  width);
        logic [31:0] p;
        logic        addressed;
        p         = 32'h0000_0000;
        addressed = w[POS_ADDRESSED];                           // [R4]
        p[7:0]    = 8'(8'h01 << w[POS_BITLOC_LO +: 3]);         // [R7]
        p[11:8]   = addressed ? DUMMY_SINGLE
                              : w[POS_DUMMY_LO +: 4];           // [R13]
        p[12]     = ~w[POS_POLARITY];                     // [R2] [R19] [R21]
        p[13]     = w[POS_AVAILABLE] &&                   // [R1] [R18]
                    (w[POS_WR_OP_LO +: 8] != OPCODE_NONE);      // [R17] [R21]
        p[14]     = w[POS_AVAILABLE] &&
                    (w[POS_RD_OP_LO +: 8] != OPCODE_NONE);      // [R16]
        p[15]     = addressed;
        p[16]     = addressed & w[POS_BYTE1];                   // [R5]
        p[17]     = addressed & w[POS_BYTE1] & (width == WIDTH_8); // [R6]
        p[18]     = pers & w[POS_RSVD_OTP];                     // [R20]
        if (!addressed) begin
            p[19] = w[POS_MODE_4S];                             // [R12]
            p[20] = w[POS_MODE_4S4D];                           // [R11]
            p[21] = w[POS_MODE_8S];                             // [R10]
            p[22] = w[POS_MODE_8D];                       // [R9] [R15]
        end else begin
            p[31:24] = w[POS_LOCAL_LO +: 8];                    // [R8]
        end
        return p;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    fetch_state_type state_q, state_d;
    logic        index_q, index_d;
    logic        done_q, done_d;
    logic [1:0]  width_q, width_d;
    logic [31:0] vol_raw_q, vol_raw_d;
    logic [31:0] per_raw_q, per_raw_d;
    logic        aw_got_q, aw_got_d;
    logic        w_got_q, w_got_d;
    logic [7:0]  aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0]  w_strb_q, w_strb_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        rvalid_q, rvalid_d;
    logic [1:0]  rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic        wr_fire;
    logic [31:0] vol_plan;
    logic [31:0] per_plan;
    logic [31:0] status_word;

    assign vol_plan    = decode_plan(vol_raw_q, WORD_VOLATILE, width_q);
    assign per_plan    = decode_plan(per_raw_q, WORD_PERSISTENT, width_q);
    assign status_word = {28'h000_0000, per_plan[17], vol_plan[17],
                          done_q, (state_q != FETCH_IDLE)};

    // Handshake outputs straight from state
    assign awready = ~aw_got_q & ~bvalid_q;
    assign wready  = ~w_got_q & ~bvalid_q;
    assign arready = ~rvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = rdata_q;
    assign link.req   = (state_q == FETCH_ASK);
    assign link.index = index_q;

    // ------------------------------------------------------------------
    // Register bus and fetch sequencer
    // ------------------------------------------------------------------
    // Address and data are latched separately so either may come first;
    // the write is acted on once both are held and no response is pending.
    always_comb begin
        state_d   = state_q;
        index_d   = index_q;
        done_d    = done_q;
        width_d   = width_q;
        vol_raw_d = vol_raw_q;
        per_raw_d = per_raw_q;
        aw_got_d  = aw_got_q | (awvalid & awready);
        w_got_d   = w_got_q | (wvalid & wready);
        aw_addr_d = (awvalid & awready) ? awaddr : aw_addr_q;
        w_data_d  = (wvalid & wready) ? wdata : w_data_q;
        w_strb_d  = (wvalid & wready) ? wstrb : w_strb_q;
        bvalid_d  = bvalid_q & ~bready;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q & ~rready;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        wr_fire   = aw_got_q & w_got_q & ~bvalid_q;

        if (wr_fire) begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = RESP_SLVERR;
            if (aw_addr_q[7:2] == OFS_CONTROL[7:2]) begin
                bresp_d = RESP_OKAY;
                if (w_strb_q[0]) begin
                    width_d = w_data_q[CTL_WIDTH_LO +: 2];
                    // A fetch asked for while one runs is ignored
                    if (w_data_q[CTL_FETCH] && state_q == FETCH_IDLE) begin
                        state_d = FETCH_ASK;
                        index_d = WORD_VOLATILE;
                        done_d  = 1'b0;
                    end
                end
            end
        end

        // Request held until the table acks, then the next word
        if (state_q == FETCH_ASK && link.ack) begin
            if (index_q == WORD_VOLATILE) begin
                vol_raw_d = link.data;
                index_d   = WORD_PERSISTENT;
            end else begin
                per_raw_d = link.data;
                state_d   = FETCH_IDLE;
                done_d    = 1'b1;
            end
        end

        if (arvalid && arready) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            case (araddr[7:2])
                OFS_CONTROL[7:2]:  rdata_d = {29'h0000_0000, width_q, 1'b0};
                OFS_STATUS[7:2]:   rdata_d = status_word;
                OFS_VOL_RAW[7:2]:  rdata_d = vol_raw_q;
                OFS_PER_RAW[7:2]:  rdata_d = per_raw_q;
                OFS_VOL_PLAN[7:2]: rdata_d = vol_plan;
                OFS_PER_PLAN[7:2]: rdata_d = per_plan;
                default: begin
                    rdata_d = RESET_WORD;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q   <= FETCH_IDLE;
            index_q   <= WORD_VOLATILE;
            done_q    <= 1'b0;
            width_q   <= RESET_WIDTH;
            vol_raw_q <= RESET_WORD;
            per_raw_q <= RESET_WORD;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= RESET_WORD;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= RESET_WORD;
        end else begin
            state_q   <= state_d;
            index_q   <= index_d;
            done_q    <= done_d;
            width_q   <= width_d;
            vol_raw_q <= vol_raw_d;
            per_raw_q <= per_raw_d;
            aw_got_q  <= aw_got_d;
            w_got_q   <= w_got_d;
            aw_addr_q <= aw_addr_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end
endmodule

/* tb/octal_enable_asserts.sv */
// Concurrent checks on the descriptor link between table and host.
// Assumes the bench hands in the link signals and the table's settings.
`timescale 1ns/1ps
module octal_enable_asserts #(
    parameter logic       VOL_AVAILABLE = 1'b1,
    parameter logic       PER_AVAILABLE = 1'b1,
    parameter logic       PER_INVERTED  = 1'b0,
    parameter logic       PER_OTP       = 1'b0,
    parameter logic [7:0] PER_MIDDLE    = 8'h00
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        req,
    input wire logic        index,
    input wire logic        ack,
    input wire logic [31:0] data
);
    // ------------------------------------------------------------------
    // Link timing and word contents
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_ACK_ONE_CYCLE: assert property (ack |=> !ack)
        else $error("ack held longer than one cycle");
    AST_ANSWER_NEXT: assert property (req && !ack |=> ack)
        else $error("request not answered in one cycle");
    AST_ACK_NEEDS_REQ: assert property (ack |-> $past(req))
        else $error("answer without a request");
    AST_INDEX_STEADY: assert property (req && !ack |=> $stable(index))
        else $error("word index moved while waiting");
    AST_VOL_THEN_PER: assert property (
        ack && !index |=> !ack ##1 (ack && index))
        else $error("persistent word did not follow volatile word");
    AST_VOL_PRESENT: assert property (
        ack && !index |-> data[31] == VOL_AVAILABLE)
        else $error("volatile presence flag wrong");
    AST_VOL_RSVD_ZERO: assert property (ack && !index |-> !data[29])
        else $error("volatile reserved bit set");
    AST_PER_FLAGS: assert property (ack && index |->
        data[31:29] == {PER_AVAILABLE, PER_INVERTED, PER_OTP})
        else $error("persistent presence, polarity or one-time flag wrong");
    AST_PER_LOCAL: assert property (ack && index && data[28] |->
        data[23:16] == PER_MIDDLE)
        else $error("persistent local address wrong");
    AST_DATA_HOLDS: assert property (ack |=> $stable(data))
        else $error("word changed right after its answer");

    // Main scenarios reached
    COV_VOL: cover property (ack && !index);
    COV_PER_BYTE1: cover property (ack && index && data[27]);
    COV_FETCH_END: cover property ($fell(req));
endmodule

/* tb/tb_top.sv */
// Self-checking bench: table and host joined by the link, host driven
// over AXI4-Lite. Assumes the package and both ends are compiled first.
`timescale 1ns/1ps
module tb_top;
    import octal_enable_pkg::*;
    // Persistent word settings chosen to exercise inverted, one-time, byte 1
    localparam logic [7:0] PMID = 8'h5A;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0]  wstrb = 4'h0, sl_dummy;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] val;
    int          miscompares = 0, checks_done = 0;

    always #4 aclk = ~aclk;

    desc_link_if desc_link_if_i ();
    octal_enable_table #(.PER_INVERTED(1'b1), .PER_OTP(1'b1),
        .PER_BYTE1(1'b1), .PER_MIDDLE(PMID)) octal_enable_table_i (
        .aclk(aclk), .aresetn(aresetn), .link(desc_link_if_i),
        .single_lane_dummy(sl_dummy));
    octal_enable_host octal_enable_host_i (
        .aclk(aclk), .aresetn(aresetn), .link(desc_link_if_i),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    octal_enable_asserts #(.PER_INVERTED(1'b1), .PER_OTP(1'b1),
        .PER_MIDDLE(PMID)) octal_enable_asserts_i (
        .aclk(aclk), .aresetn(aresetn), .req(desc_link_if_i.req),
        .index(desc_link_if_i.index), .ack(desc_link_if_i.ack),
        .data(desc_link_if_i.data));

    // ------------------------------------------------------------------
    // Verdict, comparison and bus tasks
    // ------------------------------------------------------------------
    task automatic results();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // Readiness is sampled at the falling edge, so the release at the
    // next rising edge never races the design's own updates there
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        int  n;
        bit  ta, tw, tb;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 100) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid === 1'b1;
            r = bresp;
            @(posedge aclk);
            n++;
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                return;
            end
        end
        miscompares++;
        results();
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int  n;
        bit  ta, tr;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 100) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid === 1'b1;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            n++;
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                return;
            end
        end
        miscompares++;
        results();
    endtask

    // Start a fetch at the given address width and poll until done
    task automatic fetch(input logic [1:0] w);
        int n;
        axi_write(OFS_CONTROL, {29'h0, w, 1'b1}, resp);
        check("fetch resp", {30'h0, resp}, {30'h0, RESP_OKAY});
        for (n = 0; n < 20; n++) begin
            axi_read(OFS_STATUS, val, resp);
            if (val[1] === 1'b1) return;
        end
        miscompares++;
        results();
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        check("single lane dummy", {28'h0, sl_dummy}, {28'h0, DUMMY_SINGLE});
        axi_read(OFS_CONTROL, val, resp);
        check("control reset", val, {29'h0, RESET_WIDTH, 1'b0});
        axi_read(OFS_VOL_RAW, val, resp);
        check("volatile raw reset", val, RESET_WORD);
        axi_read(8'h18, val, resp);
        check("unmapped read resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        check("unmapped read data", val, 32'h0000_0000);
        axi_write(8'h1C, 32'h0000_0001, resp);
        check("unmapped write resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        // Byte 1 placement legal at 24-bit width
        fetch(WIDTH_24);
        axi_read(OFS_VOL_RAW, val, resp);
        check("volatile word", val, {4'h8, 1'b0, 3'h0, 8'hC8,
                                     8'h05, 8'h01});
        axi_read(OFS_PER_RAW, val, resp);
        check("persistent word", val, {4'hF, 1'b1, 3'h3, PMID,
                                       8'h71, 8'h72});
        axi_read(OFS_VOL_PLAN, val, resp);
        check("volatile plan", val, 32'h0060_7801);
        axi_read(OFS_PER_PLAN, val, resp);
        check("persistent plan", val, {PMID, 24'h05_E008});
        axi_read(OFS_STATUS, val, resp);
        check("status 24-bit", val, 32'h0000_0002);
        // Same placement is illegal with 8-bit addressing
        fetch(WIDTH_8);
        axi_read(OFS_PER_PLAN, val, resp);
        check("persistent plan 8-bit", val, {PMID, 24'h07_E008});
        axi_read(OFS_STATUS, val, resp);
        check("status 8-bit", val, 32'h0000_000A);
        axi_read(OFS_CONTROL, val, resp);
        check("control width", val, {29'h0, WIDTH_8, 1'b0});
        results();
    end
endmodule
